// ### scb0_regs.sv
// System control bank zero: APB register file for clock choice, bus prescale,
// reset cause, low-voltage detector, pin takeover and vector mapping.
// Assumes pclk is the system clock; presetn is the system reset and
// por_n is a separate power-on reset, both asynchronous active low.
// Reset-cause inputs are levels held by the reset controller while presetn is low.
// Summary of operation
// RL1: Software writes clock select; 000 fast oscillator, 001 slow oscillator.
// RL2: Read-only status shows source actually clocking system; writes ignored.
// RL3: Source change waits until target oscillator is ready, then completes.
// RL4: Bus clock is system clock over two to the prescale code; reset 010.
// RL5: Power-on reset sets cause bit 4; reads one after power-up.
// RL6: Reset through external pin sets cause bit 3.
// RL7: Low-voltage detector reset sets cause bit 2.
// RL8: Watchdog reset sets cause bit 1.
// RL9: Software reset request sets cause bit 0; reads one after reset.
// RL10: Writing zero to a cause flag clears it.
// RL11: Writing one leaves flags; uninvolved flags survive non-power-on resets.
// RL12: Detector enable bit 15 resets set; bit 14 turns detection into reset.
// RL13: Interrupt threshold 01 is 2.40V, 10 is 3.30V; resets to 10.
// RL14: Interrupt threshold sits at bits 6:5; bits 4:3 read zero.
// RL15: Reset threshold 010 is 2.40V, 100 is 3.30V; resets to 010.
// RL16: Reset-pin disable zero makes pin a reset; one, its reset, GPIO.
// RL17: Debug-pin disable zero, its reset, gives debug pins; one gives GPIO.
// RL18: Mapping write needs key A5A5 in upper half; key reads zero.
// RL19: Mapping 01 user program memory, 10 RAM; resets to 01.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
module scb0_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire scb0_pkg::scb0_apb_req_type apb_req,
  output scb0_pkg::scb0_apb_rsp_type apb_rsp,
  input wire scb0_pkg::scb0_cause_type reset_cause,
  input wire logic fast_ready,
  input wire logic slow_ready,
  input wire logic low_voltage_event,
  output logic [2:0] clock_source_select,
  output logic [2:0] clock_source_status,
  output logic bus_clock_enable,
  output logic [2:0] bus_clock_divider,
  output logic detector_enable,
  output logic detector_reset_enable,
  output logic [1:0] detector_irq_threshold,
  output logic [2:0] detector_reset_threshold,
  output logic detector_reset_request,
  output logic reset_pin_disable,
  output logic debug_pin_disable,
  output logic [1:0] vector_map_select,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] prescale;
    logic det_en;
    logic det_rst_en;
    logic [1:0] irq_thr;
    logic [2:0] rst_thr;
    logic pin_dis;
    logic dbg_dis;
    logic [1:0] map;
    logic [scb0_pkg::ev_width-1:0] ev_status;
    logic [scb0_pkg::ev_width-1:0] ev_mask;
    logic [31:0] rdata;
    logic det_rst_req;
  } scb0_state_type;

  scb0_state_type r;
  scb0_state_type next_r;
  // Cause flags live on the power-on reset so they survive system resets
  logic [4:0] cause;
  logic [4:0] next_cause;
  logic in_reset;
  logic switch_done;
  logic wr;
  logic rd;
  logic [31:0] wd;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  scb0_clock_switch u_switch (
    .pclk(pclk),
    .presetn(presetn),
    .clock_source_select(r.sel),
    .fast_ready(fast_ready),
    .slow_ready(slow_ready),
    .clock_source_status(clock_source_status),
    .switch_done(switch_done)
  );

  scb0_bus_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .bus_clock_divider(r.prescale),
    .bus_clock_enable(bus_clock_enable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Zero-wait slave: every access completes in its first access cycle
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign wd = apb_req.pwdata;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_r = r;
    next_r.det_rst_req = 1'b0;
    if (wr) begin
      unique case (1'b1)
        hit(apb_req.paddr, scb0_pkg::off_system_clock_config): begin
          // RL1 source choice
          next_r.sel = wd[scb0_pkg::sel_lsb +: 3];
        end
        hit(apb_req.paddr, scb0_pkg::off_bus_clock_prescale): begin
          // RL4 prescale code
          next_r.prescale = wd[2:0];
        end
        hit(apb_req.paddr, scb0_pkg::off_low_voltage_control): begin
          // RL12 detector enables
          next_r.det_en = wd[scb0_pkg::det_en_bit];
          next_r.det_rst_en = wd[scb0_pkg::det_rst_en_bit];
          // RL14 field at 6:5
          next_r.irq_thr = wd[scb0_pkg::irq_thr_lsb +: 2];
          // RL15 reset threshold
          next_r.rst_thr = wd[scb0_pkg::rst_thr_lsb +: 3];
        end
        hit(apb_req.paddr, scb0_pkg::off_reset_pin_control): begin
          // RL16 pin takeover
          next_r.pin_dis = wd[0];
        end
        hit(apb_req.paddr, scb0_pkg::off_debug_pin_control): begin
          // RL17 debug pins
          next_r.dbg_dis = wd[0];
        end
        hit(apb_req.paddr, scb0_pkg::off_vector_table_mapping): begin
          // RL18 key gated write
          if (wd[scb0_pkg::key_lsb +: 16] == scb0_pkg::map_key) begin
            next_r.map = wd[1:0];
          end
        end
        hit(apb_req.paddr, scb0_pkg::off_irq_mask): begin
          next_r.ev_mask = wd[scb0_pkg::ev_width-1:0];
        end
        default: begin
        end
      endcase
    end
    // Write-one-to-clear; a new event in the same cycle wins
    if (wr && hit(apb_req.paddr, scb0_pkg::off_irq_status)) begin
      next_r.ev_status = r.ev_status & ~wd[scb0_pkg::ev_width-1:0];
    end
    if (switch_done) begin
      next_r.ev_status[scb0_pkg::ev_switch_done] = 1'b1;
    end
    // RL12 flag or reset
    if (low_voltage_event && r.det_en) begin
      if (r.det_rst_en) begin
        next_r.det_rst_req = 1'b1;
      end else begin
        next_r.ev_status[scb0_pkg::ev_low_voltage] = 1'b1;
      end
    end
    if (rd) begin
      next_r.rdata = 32'h0000_0000;
      unique case (1'b1)
        hit(apb_req.paddr, scb0_pkg::off_system_clock_config): begin
          // RL2 status field read only
          next_r.rdata[scb0_pkg::stat_lsb +: 3] = clock_source_status;
          next_r.rdata[scb0_pkg::sel_lsb +: 3] = r.sel;
        end
        hit(apb_req.paddr, scb0_pkg::off_bus_clock_prescale): begin
          next_r.rdata[2:0] = r.prescale;
        end
        hit(apb_req.paddr, scb0_pkg::off_reset_cause_flags): begin
          next_r.rdata[4:0] = cause;
        end
        hit(apb_req.paddr, scb0_pkg::off_low_voltage_control): begin
          next_r.rdata[scb0_pkg::det_en_bit] = r.det_en;
          next_r.rdata[scb0_pkg::det_rst_en_bit] = r.det_rst_en;
          next_r.rdata[scb0_pkg::irq_thr_lsb +: 2] = r.irq_thr;
          next_r.rdata[scb0_pkg::rst_thr_lsb +: 3] = r.rst_thr;
        end
        hit(apb_req.paddr, scb0_pkg::off_reset_pin_control): begin
          next_r.rdata[0] = r.pin_dis;
        end
        hit(apb_req.paddr, scb0_pkg::off_debug_pin_control): begin
          next_r.rdata[0] = r.dbg_dis;
        end
        hit(apb_req.paddr, scb0_pkg::off_vector_table_mapping): begin
          // RL18 key reads zero
          next_r.rdata[1:0] = r.map;
        end
        hit(apb_req.paddr, scb0_pkg::off_irq_status): begin
          next_r.rdata[scb0_pkg::ev_width-1:0] = r.ev_status;
        end
        hit(apb_req.paddr, scb0_pkg::off_irq_mask): begin
          next_r.rdata[scb0_pkg::ev_width-1:0] = r.ev_mask;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause flags

  // Remembers the system reset so causes are captured on its release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= 1'b0;
    end
  end

  always_comb begin
    next_cause = cause;
    // RL10 write zero clears
    // RL11 write one keeps
    if (wr && hit(apb_req.paddr, scb0_pkg::off_reset_cause_flags)) begin
      next_cause = cause & wd[4:0];
    end
    if (in_reset) begin
      // RL6 pin cause
      if (reset_cause.pin) next_cause[scb0_pkg::cause_pin] = 1'b1;
      // RL7 detector cause
      if (reset_cause.low_voltage) next_cause[scb0_pkg::cause_lv] = 1'b1;
      // RL8 watchdog cause
      if (reset_cause.watchdog) next_cause[scb0_pkg::cause_wdt] = 1'b1;
      // RL9 software cause
      if (reset_cause.software) next_cause[scb0_pkg::cause_sw] = 1'b1;
      // RL5 power-on cause
      if (reset_cause.power_on) next_cause[scb0_pkg::cause_por] = 1'b1;
    end
  end

  // RL5 power-on defaults
  // RL9 software flag set
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      cause <= scb0_pkg::cause_reset;
    end else begin
      cause <= next_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{sel: scb0_pkg::src_fast, prescale: scb0_pkg::prescale_reset,
             det_en: 1'b1, det_rst_en: 1'b0, irq_thr: scb0_pkg::irq_thr_reset,
             rst_thr: scb0_pkg::rst_thr_reset, pin_dis: 1'b1, dbg_dis: 1'b0,
             map: scb0_pkg::map_reset, ev_status: '0, ev_mask: '0,
             rdata: 32'h0000_0000, det_rst_req: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign apb_rsp = '{prdata: r.rdata, pready: 1'b1, pslverr: 1'b0};
  assign clock_source_select = r.sel;
  assign bus_clock_divider = r.prescale;
  assign detector_enable = r.det_en;
  assign detector_reset_enable = r.det_rst_en;
  // RL13 threshold forward
  assign detector_irq_threshold = r.irq_thr;
  assign detector_reset_threshold = r.rst_thr;
  assign detector_reset_request = r.det_rst_req;
  assign reset_pin_disable = r.pin_dis;
  assign debug_pin_disable = r.dbg_dis;
  // RL19 mapping select
  assign vector_map_select = r.map;
  assign irq = |(r.ev_status & r.ev_mask);

endmodule : scb0_regs

// ### scb0_pkg.sv
// Package for system control bank zero: register map, fields, reset values, types.
// Assumes a 32-bit APB slave with word-aligned byte offsets.
package scb0_pkg;

  localparam logic [7:0] off_system_clock_config = 8'h0c;
  localparam logic [7:0] off_bus_clock_prescale = 8'h10;
  localparam logic [7:0] off_reset_cause_flags = 8'h14;
  localparam logic [7:0] off_low_voltage_control = 8'h18;
  localparam logic [7:0] off_reset_pin_control = 8'h1c;
  localparam logic [7:0] off_debug_pin_control = 8'h20;
  localparam logic [7:0] off_vector_table_mapping = 8'h24;
  localparam logic [7:0] off_irq_status = 8'h40;
  localparam logic [7:0] off_irq_mask = 8'h44;

  localparam logic [2:0] src_fast = 3'h0;
  localparam logic [2:0] src_slow = 3'h1;
  localparam logic [2:0] prescale_reset = 3'h2;
  localparam logic [1:0] irq_thr_reset = 2'h2;
  localparam logic [2:0] rst_thr_reset = 3'h2;
  localparam logic [15:0] map_key = 16'ha5a5;
  localparam logic [1:0] map_reset = 2'h1;
  localparam logic [4:0] cause_reset = 5'h11;

  // Field positions
  localparam int sel_lsb = 0;
  localparam int stat_lsb = 4;
  localparam int det_en_bit = 15;
  localparam int det_rst_en_bit = 14;
  localparam int irq_thr_lsb = 5;
  localparam int rst_thr_lsb = 0;
  localparam int key_lsb = 16;

  // Reset cause bit numbers
  localparam int cause_por = 4;
  localparam int cause_pin = 3;
  localparam int cause_lv = 2;
  localparam int cause_wdt = 1;
  localparam int cause_sw = 0;

  // Interrupt event bits
  localparam int ev_switch_done = 0;
  localparam int ev_low_voltage = 1;
  localparam int ev_width = 2;

  typedef enum logic [0:0] {scb0_clk_idle, scb0_clk_wait} scb0_sw_state_type;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } scb0_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } scb0_apb_rsp_type;

  typedef struct packed {
    logic power_on;
    logic pin;
    logic low_voltage;
    logic watchdog;
    logic software;
  } scb0_cause_type;

endpackage : scb0_pkg

// ### scb0_clock_switch.sv
// Clock source switch sequencer: holds the live source until the target is ready.
// Assumes oscillator ready flags are synchronous to pclk.
`timescale 1ns/100ps
module scb0_clock_switch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] clock_source_select,
  input wire logic fast_ready,
  input wire logic slow_ready,
  output logic [2:0] clock_source_status,
  output logic switch_done
);

  typedef struct packed {
    scb0_pkg::scb0_sw_state_type st;
    logic [2:0] status;
    logic done;
  } scb0_sw_regs_type;

  scb0_sw_regs_type r;
  scb0_sw_regs_type next_r;
  logic target_ready;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    target_ready = (clock_source_select == scb0_pkg::src_fast) ? fast_ready :
                   (clock_source_select == scb0_pkg::src_slow) ? slow_ready : 1'b0;
    unique case (r.st)
      scb0_pkg::scb0_clk_idle: begin
        // Reserved codes never start a switch
        if (clock_source_select != r.status &&
            (clock_source_select == scb0_pkg::src_fast ||
             clock_source_select == scb0_pkg::src_slow)) begin
          next_r.st = scb0_pkg::scb0_clk_wait;
        end
      end
      scb0_pkg::scb0_clk_wait: begin
        // RL3 wait for ready
        if (clock_source_select == r.status ||
            !(clock_source_select == scb0_pkg::src_fast ||
              clock_source_select == scb0_pkg::src_slow)) begin
          next_r.st = scb0_pkg::scb0_clk_idle;
        end else if (target_ready) begin
          next_r.status = clock_source_select;
          next_r.done = 1'b1;
          next_r.st = scb0_pkg::scb0_clk_idle;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: scb0_pkg::scb0_clk_idle, status: scb0_pkg::src_fast, done: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // RL2 live source report
  assign clock_source_status = r.status;
  assign switch_done = r.done;

endmodule : scb0_clock_switch

// ### scb0_bus_divider.sv
// Core bus clock enable generator: one pulse every 2**code system clocks.
// Assumes the consumer gates its clock with the enable pulse.
`timescale 1ns/100ps
module scb0_bus_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] bus_clock_divider,
  output logic bus_clock_enable
);

  typedef struct packed {
    logic [6:0] count;
    logic tick;
  } scb0_div_regs_type;

  scb0_div_regs_type r;
  scb0_div_regs_type next_r;
  logic [6:0] limit;

  always_comb begin
    next_r = r;
    // RL4 divide by two to the code
    limit = 7'((8'h01 << bus_clock_divider) - 8'h01);
    if (r.count >= limit) begin
      next_r.count = 7'h00;
      next_r.tick = 1'b1;
    end else begin
      next_r.count = 7'(r.count + 7'h01);
      next_r.tick = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bus_clock_enable = r.tick;

endmodule : scb0_bus_divider

// ### scb0_regs_checker.sv
// Checker for system control bank zero: port timing of the register bank.
// Assumes a single pclk domain with presetn as its asynchronous reset.
`timescale 1ns/100ps
module scb0_regs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire scb0_pkg::scb0_apb_req_type apb_req,
  input wire scb0_pkg::scb0_apb_rsp_type apb_rsp,
  input wire logic slow_ready,
  input wire logic low_voltage_event,
  input wire logic [2:0] clock_source_select,
  input wire logic [2:0] clock_source_status,
  input wire logic bus_clock_enable,
  input wire logic [2:0] bus_clock_divider,
  input wire logic detector_enable,
  input wire logic detector_reset_enable,
  input wire logic detector_reset_request,
  input wire logic reset_pin_disable,
  input wire logic debug_pin_disable,
  input wire logic [1:0] vector_map_select
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_write(logic [7:0] a);
    apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == a;
  endsequence
  sequence s_keyed;
    apb_req.pwdata[31:16] == scb0_pkg::map_key;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_prescale_write: assert property (s_write(scb0_pkg::off_bus_clock_prescale) |=>
    bus_clock_divider == $past(apb_req.pwdata[2:0])) else $error("prescale not stored");
  a_map_keyed: assert property (s_write(scb0_pkg::off_vector_table_mapping) ##0 s_keyed
    |=> vector_map_select == $past(apb_req.pwdata[1:0])) else $error("keyed map lost");
  a_map_locked: assert property (s_write(scb0_pkg::off_vector_table_mapping) ##0
    apb_req.pwdata[31:16] != scb0_pkg::map_key |=> $stable(vector_map_select))
    else $error("map took unkeyed write");
  a_switch_needs_ready: assert property ($changed(clock_source_status) &&
    clock_source_status == scb0_pkg::src_slow |-> $past(slow_ready)) else $error("early switch");
  a_status_follows_sel: assert property ($changed(clock_source_status) |->
    clock_source_status == clock_source_select) else $error("status not the selection");
  a_det_reset_pulse: assert property (low_voltage_event && detector_enable &&
    detector_reset_enable |=> detector_reset_request) else $error("no detector reset");
  a_det_flag_only: assert property (!detector_reset_enable |=> !detector_reset_request)
    else $error("reset while disabled");
  a_div_one_const: assert property (bus_clock_divider == 3'h0 [*2] |-> bus_clock_enable)
    else $error("divide by one gap");
  a_div_pulse_gap: assert property (bus_clock_enable && bus_clock_divider != 3'h0 &&
    $past(bus_clock_divider, 2) == bus_clock_divider |=> !bus_clock_enable)
    else $error("enable pulses adjacent");
  a_reset_values: assert property ($rose(presetn) |-> bus_clock_divider == 3'h2 &&
    detector_enable && !detector_reset_enable && reset_pin_disable && !debug_pin_disable &&
    vector_map_select == 2'h1) else $error("bad value after reset");
  a_read_latch: assert property ($changed(apb_rsp.prdata) |->
    $past(apb_req.psel && !apb_req.penable && !apb_req.pwrite)) else $error("stray prdata");
  a_ready_no_err: assert property (apb_req.psel && apb_req.penable |->
    apb_rsp.pready && !apb_rsp.pslverr) else $error("access not answered");
endmodule : scb0_regs_checker

bind scb0_regs scb0_regs_checker u_checker (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .slow_ready(slow_ready),
  .low_voltage_event(low_voltage_event),
  .clock_source_select(clock_source_select),
  .clock_source_status(clock_source_status),
  .bus_clock_enable(bus_clock_enable),
  .bus_clock_divider(bus_clock_divider),
  .detector_enable(detector_enable),
  .detector_reset_enable(detector_reset_enable),
  .detector_reset_request(detector_reset_request),
  .reset_pin_disable(reset_pin_disable),
  .debug_pin_disable(debug_pin_disable),
  .vector_map_select(vector_map_select)
);

// ### system_control_bank_zero_tb.sv
// Testbench for system control bank zero: APB master, reset causes, ready flags.
// Assumes the checker is bound to scb0_regs from its own file.
`timescale 1ns/100ps
module system_control_bank_zero_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic por_n = 1'b0;
  scb0_pkg::scb0_apb_req_type req = '0;
  scb0_pkg::scb0_apb_rsp_type rsp;
  scb0_pkg::scb0_cause_type cause = '0;
  logic fast_ready = 1'b1;
  logic slow_ready = 1'b0;
  logic lv_event = 1'b0;
  logic [2:0] sel, stat, div, rthr;
  logic [1:0] ithr, map;
  logic bce, den, dren, dreq, pdis, ddis, irq;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  scb0_regs uut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .apb_req(req), .apb_rsp(rsp),
    .reset_cause(cause), .fast_ready(fast_ready), .slow_ready(slow_ready),
    .low_voltage_event(lv_event), .clock_source_select(sel), .clock_source_status(stat),
    .bus_clock_enable(bce), .bus_clock_divider(div), .detector_enable(den),
    .detector_reset_enable(dren), .detector_irq_threshold(ithr),
    .detector_reset_threshold(rthr), .detector_reset_request(dreq),
    .reset_pin_disable(pdis), .debug_pin_disable(ddis), .vector_map_select(map), .irq(irq)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Starts on a fresh edge so a release never meets the next setup in one step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge pclk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(a, 1'b0, 32'h0, q);
    check(q, exp);
  endtask : rd

  task automatic do_reset(input logic [4:0] c, input logic por);
    @(posedge pclk);
    cause <= c;
    presetn <= 1'b0;
    por_n <= ~por;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge pclk);
    cause <= '0;
  endtask : do_reset

  task automatic pulse_lv;
    @(posedge pclk);
    lv_event <= 1'b1;
    @(posedge pclk);
    lv_event <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse_lv
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(scb0_pkg::off_system_clock_config, 32'h0);
    rd(scb0_pkg::off_bus_clock_prescale, 32'h2);
    rd(scb0_pkg::off_reset_cause_flags, 32'h11);
    rd(scb0_pkg::off_low_voltage_control, 32'h8042);
    rd(scb0_pkg::off_reset_pin_control, 32'h1);
    rd(scb0_pkg::off_debug_pin_control, 32'h0);
    rd(scb0_pkg::off_vector_table_mapping, 32'h1);
    rd(8'h30, 32'h0);
    $display("Test reset values done");
  endtask : t_reset

  task automatic t_map;
    wr(scb0_pkg::off_vector_table_mapping, 32'h0000_0002);
    rd(scb0_pkg::off_vector_table_mapping, 32'h1);
    wr(scb0_pkg::off_vector_table_mapping, 32'ha5a4_0002);
    rd(scb0_pkg::off_vector_table_mapping, 32'h1);
    wr(scb0_pkg::off_vector_table_mapping, 32'ha5a5_0002);
    rd(scb0_pkg::off_vector_table_mapping, 32'h2);
    check({30'h0, map}, 32'h2);
    wr(scb0_pkg::off_vector_table_mapping, 32'ha5a5_0001);
    rd(scb0_pkg::off_vector_table_mapping, 32'h1);
    $display("Test vector mapping done");
  endtask : t_map

  task automatic t_rw;
    wr(scb0_pkg::off_bus_clock_prescale, 32'hffff_ffff);
    rd(scb0_pkg::off_bus_clock_prescale, 32'h7);
    check({29'h0, div}, 32'h7);
    wr(scb0_pkg::off_low_voltage_control, 32'hffff_ffff);
    rd(scb0_pkg::off_low_voltage_control, 32'hc067);
    check({25'h0, den, dren, ithr, rthr}, 32'h7f);
    wr(scb0_pkg::off_low_voltage_control, 32'h24);
    rd(scb0_pkg::off_low_voltage_control, 32'h24);
    check({25'h0, den, dren, ithr, rthr}, 32'h0c);
    wr(scb0_pkg::off_low_voltage_control, 32'h8042);
    wr(scb0_pkg::off_reset_pin_control, 32'h0);
    wr(scb0_pkg::off_debug_pin_control, 32'h1);
    rd(scb0_pkg::off_reset_pin_control, 32'h0);
    rd(scb0_pkg::off_debug_pin_control, 32'h1);
    check({30'h0, pdis, ddis}, 32'h1);
    $display("Test read write done");
  endtask : t_rw

  task automatic t_div;
    int n;
    for (int k = 0; k < 8; k++) begin
      wr(scb0_pkg::off_bus_clock_prescale, 32'(k));
      repeat (3) @(posedge pclk);
      while (bce !== 1'b1) @(posedge pclk);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (bce !== 1'b1);
      check(32'(n), 32'h1 << k);
    end
    $display("Test bus divider done");
  endtask : t_div

  task automatic t_clk;
    wr(scb0_pkg::off_system_clock_config, 32'h71);
    repeat (10) @(posedge pclk);
    rd(scb0_pkg::off_system_clock_config, 32'h01);
    slow_ready <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(scb0_pkg::off_system_clock_config, 32'h11);
    check({29'h0, stat}, 32'h1);
    check({29'h0, sel}, 32'h1);
    // Reserved code is stored but never starts a switch
    wr(scb0_pkg::off_system_clock_config, 32'h5);
    repeat (10) @(posedge pclk);
    rd(scb0_pkg::off_system_clock_config, 32'h15);
    wr(scb0_pkg::off_system_clock_config, 32'h0);
    repeat (10) @(posedge pclk);
    rd(scb0_pkg::off_system_clock_config, 32'h00);
    $display("Test clock switch done");
  endtask : t_clk

  task automatic t_irq;
    rd(scb0_pkg::off_irq_status, 32'h1);
    wr(scb0_pkg::off_irq_status, 32'h3);
    wr(scb0_pkg::off_irq_mask, 32'h2);
    pulse_lv();
    check({31'h0, irq}, 32'h1);
    rd(scb0_pkg::off_irq_status, 32'h2);
    wr(scb0_pkg::off_irq_status, 32'h2);
    rd(scb0_pkg::off_irq_status, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(scb0_pkg::off_irq_mask, 32'h0);
    pulse_lv();
    check({31'h0, irq}, 32'h0);
    wr(scb0_pkg::off_irq_status, 32'h2);
    // Reset-enabled detection must leave the flag alone
    wr(scb0_pkg::off_low_voltage_control, 32'hc042);
    @(posedge pclk);
    lv_event <= 1'b1;
    @(posedge pclk);
    lv_event <= 1'b0;
    @(negedge pclk);
    check({31'h0, dreq}, 32'h1);
    rd(scb0_pkg::off_irq_status, 32'h0);
    wr(scb0_pkg::off_low_voltage_control, 32'h8042);
    $display("Test interrupt done");
  endtask : t_irq

  task automatic t_cause;
    wr(scb0_pkg::off_reset_cause_flags, 32'h1e);
    rd(scb0_pkg::off_reset_cause_flags, 32'h10);
    do_reset(5'h0a, 1'b0);
    rd(scb0_pkg::off_reset_cause_flags, 32'h1a);
    do_reset(5'h05, 1'b0);
    rd(scb0_pkg::off_reset_cause_flags, 32'h1f);
    wr(scb0_pkg::off_reset_cause_flags, 32'h0);
    rd(scb0_pkg::off_reset_cause_flags, 32'h0);
    do_reset(5'h00, 1'b1);
    rd(scb0_pkg::off_reset_cause_flags, 32'h11);
    $display("Test reset cause done");
  endtask : t_cause
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // Whole run needs under a thousand cycles; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_map();
    t_rw();
    t_div();
    t_clk();
    t_irq();
    t_cause();
    finish_test();
  end
endmodule : system_control_bank_zero_tb
